//--- gx_expander.sv
// i2c target register and transaction logic of an 8-bit port expander
// How it works
// - after read ack, device shifts register data
// - unaddressed command-only read gets no ack
// - address 0x20 or 0x21 by select pin
// - address last bit: 1 read, 0 write
// - first written byte goes to selector
// - low two selector bits pick register
// - selector is writable; reads back only when upper six bits set
// - input register shows pins, ignores writes
// - latch drives outputs, reads latch, resets ones
// - invert mask flips input pins, resets zero
// - direction 1 input, 0 output, resets ones
// - stop anytime; last acked data stands
// - selector persists across transactions
// - reset low holds registers and engine
`timescale 1ns/1ps
module gx_expander (
    input  wire logic       mclk_i,          // 40 MHz system clock
    input  wire logic       resetn_i,        // sync reset, active low
    input  wire logic       rst_pin_n_i,     // device reset pin
    input  wire logic       addr_sel_i,      // address select pin
    input  wire logic       scl_i,           // bus clock pin level
    input  wire logic       sda_i,           // bus data pin level
    output logic            sda_o,           // data pin drive level
    output logic            sda_oe_n_o,      // low while pulling sda
    input  wire logic [7:0] port_pin_i,      // sensed port levels
    output logic      [7:0] port_pin_o,      // port drive levels
    output logic      [7:0] port_pin_oe_n_o  // low while driving
);
    import gx_pkg::*;

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    logic [11:0] sync1;      // first stage, read only by sync2
    logic [11:0] sync2;      // second stage, safe to use
    logic        scl_q;      // previous scl sample
    logic        sda_q;      // previous sda sample

    // all pins share one two-stage chain
    always_ff @(posedge mclk_i) begin
        sync1 <= {rst_pin_n_i, addr_sel_i, scl_i, sda_i, port_pin_i};
        sync2 <= sync1;
        scl_q <= sync2[9];
        sda_q <= sync2[8];
    end

    logic [7:0] pin_s;       // synced port levels
    logic       scl_s;       // synced scl
    logic       sda_s;       // synced sda
    logic       rst;         // combined active-high reset
    assign pin_s = sync2[7:0];
    assign scl_s = sync2[9];
    assign sda_s = sync2[8];
    // reset pin is only honoured once synced, so a glitch cannot split
    // the register file across two clock edges
    assign rst   = !resetn_i || !sync2[11];

    // bus events seen on the system clock
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_c  = scl_s && scl_q && sda_q && !sda_s;
    assign stop_c   = scl_s && scl_q && !sda_q && sda_s;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    gx_regs_t   regs;        // writable port registers
    logic [7:0] sel;         // register_selector
    logic [7:0] in_lvl;      // pin_input_levels view
    logic [7:0] rd_val;      // value offered to a read
    logic [6:0] my_addr;     // our target address

    assign my_addr = {ADDR_HI, sync2[10]};
    // inversion applies to input-configured pins only
    assign in_lvl  = pin_s ^ (regs.inv & regs.dir);

    // read mux; a selector with upper bits set reads itself back
    always_comb begin
        rd_val = sel;
        if (sel[7:2] == 6'h00) begin
            case (sel[1:0])
                SEL_INPUT:  rd_val = in_lvl;
                SEL_OUTPUT: rd_val = regs.out;
                SEL_INVERT: rd_val = regs.inv;
                default:    rd_val = regs.dir;
            endcase
        end
    end

    // port drivers come straight from latch and direction flops
    assign port_pin_o      = regs.out;
    assign port_pin_oe_n_o = regs.dir;

    // ----------------------------------------------------------------
    // bus engine
    // ----------------------------------------------------------------
    gx_state_t  state;       // engine state
    gx_kind_t   kind;        // meaning of byte under receive
    logic [3:0] bitcnt;      // bits moved in this byte
    logic [7:0] rx_sh;       // receive shifter
    logic [7:0] tx_sh;       // transmit shifter
    logic       ack_tx;      // after our ack, go transmit
    logic       m_ack;       // controller acked our byte
    logic       byte_done;   // eighth bit received, ack slot next

    assign byte_done = (state == ST_RX) && scl_fall && bitcnt == BYTE_BITS;

    // open drain: only ever pull low
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = !((state == ST_ACK) ||
                          (state == ST_TX && !tx_sh[7]));

    // state, counters and shifters
    always_ff @(posedge mclk_i) begin
        if (rst) begin
            state  <= ST_IDLE;
            kind   <= K_ADDR;
            bitcnt <= 4'h0;
            rx_sh  <= 8'h00;
            tx_sh  <= 8'hFF;
            ack_tx <= 1'b0;
            m_ack  <= 1'b0;
        end else if (start_c) begin
            // start or repeated start always re-arms address receive
            state  <= ST_RX;
            kind   <= K_ADDR;
            bitcnt <= 4'h0;
        end else if (stop_c) begin
            state  <= ST_IDLE;
        end else begin
            case (state)
                ST_RX: begin
                    if (scl_rise && bitcnt != BYTE_BITS) begin
                        rx_sh  <= {rx_sh[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (byte_done) begin
                        bitcnt <= 4'h0;
                        ack_tx <= 1'b0;
                        state  <= ST_ACK;
                        case (kind)
                            K_ADDR: begin
                                // foreign address: stay off the bus
                                if (rx_sh[7:1] != my_addr) begin
                                    state <= ST_WAIT;
                                end else if (rx_sh[0]) begin
                                    ack_tx <= 1'b1;
                                end else begin
                                    kind <= K_CMD;
                                end
                            end
                            default: begin
                                kind <= K_DATA;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // hold ack low through the ninth clock
                    if (scl_fall) begin
                        bitcnt <= 4'h0;
                        tx_sh  <= rd_val;
                        state  <= ack_tx ? ST_TX : ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == TX_LAST) begin
                            state <= ST_TXACK;
                        end else begin
                            tx_sh  <= {tx_sh[6:0], 1'b1};
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        m_ack <= !sda_s;
                    end else if (scl_fall) begin
                        // no auto increment: same register again
                        bitcnt <= 4'h0;
                        tx_sh  <= rd_val;
                        state  <= m_ack ? ST_TX : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    state <= ST_WAIT;  // released until start or stop
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // selector capture; writes take effect at the ack slot
    always_ff @(posedge mclk_i) begin
        if (rst) begin
            sel <= SEL_RST;
        end else if (byte_done && kind == K_CMD) begin
            sel <= rx_sh;
        end
    end

    // data writes; the input register silently drops them
    always_ff @(posedge mclk_i) begin
        if (rst) begin
            regs <= '{OUT_RST, INV_RST, DIR_RST};
        end else if (byte_done && kind == K_DATA &&
                     sel[7:2] == 6'h00) begin
            case (sel[1:0])
                SEL_OUTPUT: regs.out <= rx_sh;
                SEL_INVERT: regs.inv <= rx_sh;
                SEL_DIR:    regs.dir <= rx_sh;
                default:    regs.out <= regs.out;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst);

    rst_defaults_a: assert property (disable iff (1'b0) rst |=>
        state == ST_IDLE && regs.out == OUT_RST && regs.dir == DIR_RST)
        else $error("reset did not restore defaults");
    addr_nack_a: assert property (byte_done && kind == K_ADDR &&
        rx_sh[7:1] != my_addr |=> sda_oe_n_o [*2])
        else $error("foreign address was acknowledged");
    addr_ack_a: assert property (byte_done && kind == K_ADDR &&
        rx_sh[7:1] == my_addr && !start_c && !stop_c
        |=> !sda_oe_n_o && ack_tx == $past(rx_sh[0]))
        else $error("own address not acknowledged");
    cmd_cap_a: assert property (byte_done && kind == K_CMD &&
        !start_c && !stop_c |=> sel == $past(rx_sh) && kind == K_DATA)
        else $error("command byte not captured");
    in_ignore_a: assert property (byte_done && kind == K_DATA &&
        sel == 8'h00 |=> $stable(regs))
        else $error("input register write changed state");
    wr_commit_a: assert property (byte_done && kind == K_DATA &&
        sel == 8'h01 |=> regs.out == $past(rx_sh) && port_pin_o == regs.out)
        else $error("output latch write lost");
    ack_load_a: assert property (state == ST_ACK && scl_fall && ack_tx
        && !start_c && !stop_c |=> state == ST_TX && tx_sh == $past(rd_val))
        else $error("read data not loaded after ack");
    keep_sel_a: assert property (state == ST_TXACK &&
        scl_fall && m_ack && !start_c && !stop_c
        |=> state == ST_TX && $stable(sel))
        else $error("repeated read moved selector");
    // a nack ends the read: the line must be free for the stop
    nack_free_a: assert property (state == ST_TXACK &&
        scl_fall && !m_ack && !start_c && !stop_c |=> sda_oe_n_o [*2])
        else $error("data line held after controller nack");

    read_seen_c:  cover property (state == ST_TXACK ##[1:400] state == ST_TX);
    write_seen_c: cover property (byte_done && kind == K_DATA);
    nack_seen_c:  cover property (state == ST_RX ##1 state == ST_WAIT);
endmodule // gx_expander

//--- gx_pkg.sv
// package of constants and types for the i2c gpio expander
package gx_pkg;
    // ----------------------------------------------------------------
    // target address and register selector encodings
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_HI     = 6'h10; // upper six address bits
    localparam logic [1:0] SEL_INPUT   = 2'h0;  // pin_input_levels
    localparam logic [1:0] SEL_OUTPUT  = 2'h1;  // pin_output_latch
    localparam logic [1:0] SEL_INVERT  = 2'h2;  // input_invert_mask
    localparam logic [1:0] SEL_DIR     = 2'h3;  // pin_direction
    localparam logic [3:0] BYTE_BITS   = 4'h8;  // bits per byte
    localparam logic [3:0] TX_LAST     = 4'h7;  // last driven bit index
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] OUT_RST     = 8'hFF;
    localparam logic [7:0] INV_RST     = 8'h00;
    localparam logic [7:0] DIR_RST     = 8'hFF;
    localparam logic [7:0] SEL_RST     = 8'h00;

    // writable port registers, carried as one bundle
    typedef struct packed {
        logic [7:0] out;   // pin_output_latch
        logic [7:0] inv;   // input_invert_mask
        logic [7:0] dir;   // pin_direction, 1 = input
    } gx_regs_t;

    // bus engine states
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_WAIT
    } gx_state_t;

    // meaning of the byte being received
    typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} gx_kind_t;
endpackage : gx_pkg

//--- gx_host.sv
// i2c controller model driving the expander bus pins
`timescale 1ns/1ps
module gx_host (
    input  wire logic mclk_i,    // system clock, paces the bus
    input  wire logic sda_i,     // resolved data wire
    output logic      scl_o,     // bus clock, stands high when idle
    output logic      sda_low_o  // high while pulling sda low
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    // four mclk per half period gives a 200 ns bus clock
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // start or repeated start: sda falls while scl is high
    task automatic start();
        tick(2);
        sda_low_o = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        sda_low_o = 1'b1;
        tick(2);
        scl_o = 1'b0;
    endtask
    // stop: sda rises while scl is high
    task automatic stop();
        tick(2);
        sda_low_o = 1'b1;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        sda_low_o = 1'b0;
        tick(4);
    endtask
    // data moves mid low phase, sampled late in the high phase
    task automatic xfer_bit(input logic b, output logic r);
        tick(2);
        sda_low_o = !b;
        tick(2);
        scl_o = 1'b1;
        tick(3);
        r = sda_i;
        tick(1);
        scl_o = 1'b0;
    endtask
    // byte out msb first, sda released for the ack slot
    task automatic wbyte(input logic [7:0] d,
                         output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = !r;
    endtask
    // byte in; ack asks for more, nack ends the read
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(1'b1, d[i]);
        xfer_bit(!more, r);
    endtask
endmodule // gx_host

//--- gx_expander_bench.sv
// self-checking bench of the expander register and bus logic
`timescale 1ns/1ps
module gx_expander_bench;
    import gx_pkg::*;
    logic       mclk, resetn, rst_pin_n, addr_sel;
    logic       scl, sda, sda_low, sda_drv, sda_oe_n;
    logic [7:0] port_in, port_out, port_oe_n;
    int         fail_count  = 0;
    int         checks_done = 0;
    // pull-up on sda: low when either party pulls
    assign sda = !(sda_low || (!sda_oe_n && !sda_drv));
    gx_expander dut_u (.mclk_i(mclk), .resetn_i(resetn),
        .rst_pin_n_i(rst_pin_n), .addr_sel_i(addr_sel), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_drv), .sda_oe_n_o(sda_oe_n),
        .port_pin_i(port_in), .port_pin_o(port_out),
        .port_pin_oe_n_o(port_oe_n));
    gx_host h_u (.mclk_i(mclk), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [7:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask
    // address, selector, one data byte, stop; all three acked
    task automatic wreg(input logic [7:0] sel, d);
        logic k0, k1, k2;
        h_u.start();
        h_u.wbyte({7'h20, 1'b0}, k0);
        h_u.wbyte(sel, k1);
        h_u.wbyte(d, k2);
        h_u.stop();
        chk("write acks", 8'h07, {5'h00, k0, k1, k2});
    endtask
    // two-byte read, optionally without a new selector
    task automatic rreg(input logic [7:0] sel, input logic skip,
                        output logic [7:0] d0, d1);
        logic k;
        if (!skip) begin
            h_u.start();
            h_u.wbyte({7'h20, 1'b0}, k);
            h_u.wbyte(sel, k);
        end
        h_u.start();
        h_u.wbyte({7'h20, 1'b1}, k);
        chk("read ack", 8'h01, {7'h00, k});
        h_u.rbyte(1'b1, d0);
        h_u.rbyte(1'b0, d1);
        h_u.stop();
        // a target still driving after the nack would swallow the stop
        chk("bus free", 8'h01, {7'h00, sda});
    endtask
    task automatic t_reset();
        logic [7:0] a, b;
        chk("latch pins", 8'hFF, port_out);
        chk("dir pins", 8'hFF, port_oe_n);
        rreg(8'h02, 1'b0, a, b);
        chk("invert reset", 8'h00, a);
        rreg(8'h03, 1'b0, a, b);
        chk("dir reset", 8'hFF, a);
        $display("test reset done");
    endtask
    task automatic t_addr();
        logic k;
        for (int s = 0; s < 2; s++) begin
            addr_sel = s[0];
            repeat (4) @(negedge mclk);
            for (int a = 32; a < 34; a++) begin
                h_u.start();
                h_u.wbyte({a[6:0], 1'b0}, k);
                h_u.stop();
                chk("addr ack", {7'h00, a[0] == s[0]}, {7'h00, k});
            end
        end
        addr_sel = 1'b0;
        repeat (4) @(negedge mclk);
        h_u.start();
        h_u.wbyte({7'h21, 1'b1}, k);
        h_u.stop();
        chk("bare read nack", 8'h00, {7'h00, k});
        $display("test address done");
    endtask
    task automatic t_regs();
        logic [7:0] a, b;
        logic       k;
        wreg(8'h01, 8'h5A);
        wreg(8'h03, 8'h0F);
        chk("latch pins", 8'h5A, port_out);
        chk("dir pins", 8'h0F, port_oe_n);
        port_in = 8'h3C;
        rreg(8'h01, 1'b0, a, b);
        chk("latch read", 8'h5A, a);
        wreg(8'h02, 8'hFF);
        wreg(8'h00, 8'h99);
        rreg(8'h00, 1'b0, a, b);
        chk("input read", 8'h33, a);
        chk("second byte", 8'h33, b);
        rreg(8'h55, 1'b1, a, b);
        chk("stored select", 8'h33, a);
        h_u.start();
        h_u.wbyte({7'h20, 1'b0}, k);
        h_u.wbyte(8'h85, k);
        h_u.stop();
        rreg(8'h00, 1'b1, a, b);
        chk("select read", 8'h85, a);
        // data behind a selector with upper bits set must be dropped
        wreg(8'h85, 8'h00);
        chk("latch kept", 8'h5A, port_out);
        $display("test registers done");
    endtask
    task automatic t_stop();
        logic       k;
        logic [7:0] a, b;
        h_u.start();
        h_u.wbyte({7'h20, 1'b0}, k);
        h_u.wbyte(8'h01, k);
        h_u.wbyte(8'hC3, k);
        for (int i = 0; i < 4; i++)
            h_u.xfer_bit(1'b0, k);
        h_u.stop();
        chk("latch after stop", 8'hC3, port_out);
        rst_pin_n = 1'b0;
        repeat (4) @(negedge mclk);
        rst_pin_n = 1'b1;
        repeat (4) @(negedge mclk);
        chk("latch pins", 8'hFF, port_out);
        chk("dir pins", 8'hFF, port_oe_n);
        rreg(8'h02, 1'b0, a, b);
        chk("invert after reset", 8'h00, a);
        $display("test stop and reset done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        resetn    = 1'b0;
        rst_pin_n = 1'b1;
        addr_sel  = 1'b0;
        port_in   = 8'h00;
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset();
        t_addr();
        t_regs();
        t_stop();
        wrap_up();
    end
    // the run needs about 4500 cycles; this cuts a hang short
    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end
endmodule // gx_expander_bench
